/* File: rtl/ppc_dpram.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_dpram #(
  parameter int AW = 8,
  parameter int DW = 24
) (
  input wire logic clk_i,
  input wire logic ce_i,
  ppc_ram_if.mem ram
);
  // Contents are left uninitialised, so no reset on the array
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && ram.we)
    begin
      mem_q[ram.waddr] <= ram.wdata;
    end
  end

  // Asynchronous read: the caller registers the result
  assign ram.rdata = mem_q[ram.raddr];
endmodule
`default_nettype wire

/* File: rtl/ppc_pixel_pipeline.sv */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ppc_pixel_pipeline
  import ppc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pixel_clock_i,
  input wire logic hsync_n_i,
  input wire logic vsync_n_i,
  input wire logic blank_n_i,
  input wire logic field_i,
  input wire logic [63:0] pixel_word_in_i,
  output logic fifo_pop_o,
  output logic [7:0] alpha_o,
  output logic [7:0] red_o,
  output logic [7:0] green_o,
  output logic [7:0] blue_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic blank_n_o,
  output logic field_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  typedef struct packed {
    logic [1:0] pclk_s;
    logic pclk_d;
    logic [1:0][3:0] tim_s;
    logic [1:0][63:0] word_s;
    logic [31:0] ctrl;
    logic [11:0] cpos_x;
    logic [11:0] cpos_y;
    logic [23:0] ccol0;
    logic [23:0] ccol1;
    ppc_bus_t bus;
    logic [31:0] prdata;
    logic [PIPE_STAGES-1:0][3:0] tim;
    logic [2:0] lane;
    logic pop;
    logic [63:0] s1_word;
    logic [2:0] s1_lane;
    logic [31:0] s2_pix;
    logic s2_is8;
    logic [31:0] s3_pix;
    logic s3_is8;
    logic [31:0] s4_col;
    logic [31:0] s5_col;
    logic [1:0] s5_plane;
    logic s5_incur;
    logic [31:0] s6_col;
    logic [31:0] out_col;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [31:0] sh0;
    logic [31:0] sh1;
  } ppc_state_t;

  ppc_state_t q;
  ppc_state_t n;

  ppc_ram_if #(.AW(CLUT_AW), .DW(CLUT_DW)) clut_if ();
  ppc_ram_if #(.AW(CUR_AW), .DW(CUR_DW)) cur0_if ();
  ppc_ram_if #(.AW(CUR_AW), .DW(CUR_DW)) cur1_if ();

  ppc_dpram #(.AW(CLUT_AW), .DW(CLUT_DW)) u_clut (
    .clk_i(mclk_i), .ce_i(ce_i), .ram(clut_if.mem));
  ppc_dpram #(.AW(CUR_AW), .DW(CUR_DW)) u_cur0 (
    .clk_i(mclk_i), .ce_i(ce_i), .ram(cur0_if.mem));
  ppc_dpram #(.AW(CUR_AW), .DW(CUR_DW)) u_cur1 (
    .clk_i(mclk_i), .ce_i(ce_i), .ram(cur1_if.mem));

  function automatic ppc_kind_t addr_kind(input logic [APB_AW-1:0] a);
    ppc_kind_t k;
    k = AK_NONE;
    if (a[APB_AW-1 -: 2] == CLUT_PAGE)
      k = AK_CLUT;
    else if (a[APB_AW-1 -: 4] == CUR_PAGE)
      k = AK_CUR;
    else if (a == OFF_CTRL)
      k = AK_CTRL;
    else if (a == OFF_CPOS)
      k = AK_CPOS;
    else if (a == OFF_CNT)
      k = AK_CNT;
    else if (a == OFF_CCOL0)
      k = AK_CCOL0;
    else if (a == OFF_CCOL1)
      k = AK_CCOL1;
    return k;
  endfunction

  function automatic logic [2:0] lane_last(input ppc_psize_t s);
    logic [2:0] r;
    case (s)
      PS_8: r = 3'h7;
      PS_16: r = 3'h3;
      default: r = 3'h1;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] expand16(input logic [15:0] p,
    input ppc_fmt_t f);
    logic [31:0] r;
    case (f)
      FMT_4444: r = {p[15:12], p[15:12], p[11:8], p[11:8],
        p[7:4], p[7:4], p[3:0], p[3:0]};
      default: r = {ALPHA_OPAQUE, p[15:11], p[15:13], p[10:5], p[10:9],
        p[4:0], p[4:2]};
    endcase
    return r;
  endfunction

  // Byte 0 of a line holds the leftmost eight pixels, msb first
  function automatic logic [31:0] line_order(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  ppc_kind_t kind;
  ppc_psize_t psize;
  ppc_fmt_t fmt;
  logic adv;
  logic setup;
  logic acc;
  logic mem_rd;
  logic rd_bus;
  logic we_any;
  logic cur_on;
  logic [11:0] row;
  logic [12:0] dx;
  logic [12:0] dy;
  logic in_h;
  logic in_v;
  logic [63:0] lane_word;
  logic [31:0] reg_rd;

  assign kind = addr_kind(paddr_i);
  assign psize = ppc_psize_t'(q.ctrl[CC_SIZE_LSB +: 2]);
  assign fmt = ppc_fmt_t'(q.ctrl[CC_FMT_LSB +: 2]);
  // Dot clock is sampled: its rising edge becomes a one-cycle step
  assign adv = q.pclk_s[1] & ~q.pclk_d;
  assign setup = ce_i & psel_i & ~penable_i;
  assign acc = ce_i & psel_i & penable_i;
  assign mem_rd = (kind == AK_CUR || kind == AK_CLUT) && !pwrite_i;
  assign rd_bus = (q.bus != BS_IDLE);
  assign pready_o = acc && (!mem_rd || q.bus == BS_HOLD2);
  assign pslverr_o = pready_o && kind == AK_NONE;
  assign we_any = acc && pwrite_i;
  assign cur_on = q.ctrl[CU_ON_BIT];

  // Interlaced frames count field lines; the field bit adds the row lsb
  assign row = q.ctrl[CU_ILACE_BIT] ?
    {q.vcnt[10:0], q.tim[3][TB_FLD] ^ q.ctrl[CU_POL_BIT]} : q.vcnt;
  assign dx = {1'b0, q.hcnt} - {1'b0, q.cpos_x};
  assign dy = {1'b0, row} - {1'b0, q.cpos_y};
  assign in_h = !dx[12] && dx[11:0] < CUR_DIM;
  assign in_v = !dy[12] && dy[11:0] < CUR_DIM;

  // Bus writes land at the completing edge; reads share the read port
  assign clut_if.we = we_any && kind == AK_CLUT;
  assign clut_if.waddr = paddr_i[WORD_LSB +: CLUT_AW];
  assign clut_if.wdata = pwdata_i[CLUT_DW-1:0];
  assign clut_if.raddr = rd_bus ?
    paddr_i[WORD_LSB +: CLUT_AW] : q.s3_pix[CLUT_AW-1:0];
  assign cur0_if.we = we_any && kind == AK_CUR && !paddr_i[CUR_PLANE_BIT];
  assign cur1_if.we = we_any && kind == AK_CUR && paddr_i[CUR_PLANE_BIT];
  assign cur0_if.waddr = paddr_i[WORD_LSB +: CUR_AW];
  assign cur1_if.waddr = paddr_i[WORD_LSB +: CUR_AW];
  assign cur0_if.wdata = pwdata_i;
  assign cur1_if.wdata = pwdata_i;
  assign cur0_if.raddr = rd_bus ?
    paddr_i[WORD_LSB +: CUR_AW] : dy[CUR_AW-1:0];
  assign cur1_if.raddr = rd_bus ?
    paddr_i[WORD_LSB +: CUR_AW] : dy[CUR_AW-1:0];

  always_comb
  begin
    case (kind)
      AK_CTRL: reg_rd = q.ctrl;
      AK_CPOS: reg_rd = (32'(q.cpos_x) << POS_X_LSB) | 32'(q.cpos_y);
      AK_CNT: reg_rd = (32'(q.hcnt) << POS_X_LSB) | 32'(q.vcnt);
      AK_CCOL0: reg_rd = {8'h00, q.ccol0};
      AK_CCOL1: reg_rd = {8'h00, q.ccol1};
      default: reg_rd = 32'h0000_0000;
    endcase
    case (psize)
      PS_8: lane_word = q.s1_word >> {q.s1_lane, 3'h0};
      PS_16: lane_word = q.s1_word >> {q.s1_lane[1:0], 4'h0};
      default: lane_word = q.s1_word >> {q.s1_lane[0], 5'h00};
    endcase
  end

  always_comb
  begin
    n = q;
    n.pclk_s = {q.pclk_s[0], pixel_clock_i};
    n.pclk_d = q.pclk_s[1];
    n.tim_s = {q.tim_s[0], field_i, blank_n_i, vsync_n_i, hsync_n_i};
    n.word_s = {q.word_s[0], pixel_word_in_i};
    n.pop = 1'b0;

    // System-clock side: register writes and the bus read sequencer
    if (we_any)
    begin
      case (kind)
        AK_CTRL: n.ctrl = pwdata_i & CTRL_MASK;
        AK_CPOS:
        begin
          n.cpos_x = pwdata_i[POS_X_LSB +: 12];
          n.cpos_y = pwdata_i[11:0];
        end
        AK_CCOL0: n.ccol0 = pwdata_i[23:0];
        AK_CCOL1: n.ccol1 = pwdata_i[23:0];
        default: n.ctrl = q.ctrl;
      endcase
    end
    case (q.bus)
      BS_IDLE:
      begin
        if (setup && mem_rd)
          n.bus = BS_HOLD1;
        else if (setup)
          n.prdata = reg_rd;
      end
      BS_HOLD1:
      begin
        n.bus = BS_HOLD2;
        if (kind == AK_CLUT)
          n.prdata = {8'h00, clut_if.rdata};
        else
          n.prdata = paddr_i[CUR_PLANE_BIT] ? cur1_if.rdata : cur0_if.rdata;
      end
      BS_HOLD2:
      begin
        if (pready_o)
          n.bus = BS_IDLE;
      end
      default: n.bus = BS_IDLE;
    endcase

    // Dot-clock side: every stage moves on one sampled edge
    if (adv)
    begin
      n.tim = {q.tim[PIPE_STAGES-2:0], q.tim_s[1]};
      // Stage 1: fetch and lane index
      if (q.tim_s[1][TB_BLK])
      begin
        n.s1_lane = q.lane;
        if (q.lane == 3'h0)
        begin
          n.s1_word = q.word_s[1];
          n.pop = 1'b1;
        end
        n.lane = (q.lane == lane_last(psize)) ? 3'h0 : q.lane + 3'h1;
      end
      else
      begin
        n.lane = 3'h0;
        n.s1_lane = 3'h0;
      end
      // Stage 2: lane select and 16-bit expansion
      n.s2_is8 = (psize == PS_8);
      case (psize)
        PS_8: n.s2_pix = {24'h00_0000, lane_word[7:0]};
        PS_16: n.s2_pix = expand16(lane_word[15:0], fmt);
        default: n.s2_pix = lane_word[31:0];
      endcase
      // Stages 3 and 4: table lookup, or plain delay for direct colour
      n.s3_pix = q.s2_pix;
      n.s3_is8 = q.s2_is8;
      // A bus read owns the table address, so this stage holds its data
      if (!rd_bus)
        n.s4_col = q.s3_is8 ? {ALPHA_LUT, clut_if.rdata} : q.s3_pix;
      // Stage 5: cursor window and plane bits
      n.s5_col = q.s4_col;
      n.s5_plane = {q.sh1[31], q.sh0[31]};
      n.s5_incur = cur_on && q.tim[3][TB_BLK] && in_h;
      if (q.tim[3][TB_BLK])
      begin
        n.hcnt = q.hcnt + 12'h001;
        if (in_h)
        begin
          n.sh0 = {q.sh0[30:0], 1'b0};
          n.sh1 = {q.sh1[30:0], 1'b0};
        end
      end
      else
      begin
        n.hcnt = 12'h000;
        if (q.tim[4][TB_BLK])
          n.vcnt = q.vcnt + 12'h001;
        if (!rd_bus)
        begin
          n.sh0 = in_v ? line_order(cur0_if.rdata) : 32'h0000_0000;
          n.sh1 = in_v ? line_order(cur1_if.rdata) : 32'h0000_0000;
        end
      end
      if (!q.tim[3][TB_VS])
        n.vcnt = 12'h000;
      // Stage 6: cursor colour selection
      n.s6_col = q.s5_col;
      if (q.s5_incur)
      begin
        if (!q.ctrl[CU_TYPE_BIT])
        begin
          case (q.s5_plane)
            2'h0: n.s6_col = {q.s5_col[31:24], q.ccol0};
            2'h1: n.s6_col = {q.s5_col[31:24], q.ccol1};
            2'h3: n.s6_col = {q.s5_col[31:24], ~q.s5_col[23:0]};
            default: n.s6_col = q.s5_col;
          endcase
        end
        else
        begin
          case (q.s5_plane)
            2'h2: n.s6_col = {q.s5_col[31:24], q.ccol0};
            2'h3: n.s6_col = {q.s5_col[31:24], q.ccol1};
            default: n.s6_col = q.s5_col;
          endcase
        end
      end
      // Stage 7: output register
      n.out_col = q.ctrl[CC_OFF_BIT] ? 32'h0000_0000 : q.s6_col;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else if (ce_i)
      q <= n;
  end

  assign fifo_pop_o = q.pop;
  assign {alpha_o, red_o, green_o, blue_o} = q.out_col;
  assign hsync_n_o = q.tim[PIPE_STAGES-1][TB_HS];
  assign vsync_n_o = q.tim[PIPE_STAGES-1][TB_VS];
  assign blank_n_o = q.tim[PIPE_STAGES-1][TB_BLK];
  assign field_o = q.tim[PIPE_STAGES-1][TB_FLD];
  assign prdata_o = q.prdata;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pop_when_active: assert property (
    (fifo_pop_o && $past(ce_i)) |-> $past(adv && q.tim_s[1][TB_BLK]))
    else $error("fifo pop outside active video");
  a_pop_pacing: assert property (
    fifo_pop_o |-> q.lane == 3'h1)
    else $error("pop not at start of a word");
  a_lane_restart: assert property (
    (ce_i && adv && !q.tim_s[1][TB_BLK]) |=> q.lane == 3'h0)
    else $error("lane index not cleared in blanking");
  a_timing_delay: assert property (
    (ce_i && adv) |=> {field_o, blank_n_o, vsync_n_o, hsync_n_o}
      == $past(q.tim[PIPE_STAGES-2]))
    else $error("timing outputs misaligned");
  a_direct_one_stage: assert property (
    (ce_i && adv && psize == PS_32 && q.s1_lane == 3'h0)
      |=> q.s2_pix == $past(q.s1_word[31:0]))
    else $error("direct pixel not selected in one stage");
  a_expand_565: assert property (
    (ce_i && adv && psize == PS_16 && fmt == FMT_565)
      |=> q.s2_pix[31:24] == ALPHA_OPAQUE)
    else $error("565 expansion alpha wrong");
  a_colour_off: assert property (
    (ce_i && adv && q.ctrl[CC_OFF_BIT])
      |=> {alpha_o, red_o, green_o, blue_o} == 32'h0000_0000)
    else $error("colour outputs not forced off");
  a_cursor_off: assert property (
    (ce_i && adv && !cur_on) ##1 (ce_i && adv)[*1]
      |=> q.s6_col == $past(q.s5_col))
    else $error("disabled cursor altered colour");
  a_mem_wait: assert property (
    (setup && mem_rd && q.bus == BS_IDLE) ##1 ce_i
      |-> q.bus == BS_HOLD1 && !pready_o)
    else $error("memory read answered without hold");
  a_lut_freeze: assert property (
    (ce_i && rd_bus) |=> $stable(q.s4_col))
    else $error("lookup output moved during bus read");

  c_fifo_pop: cover property (fifo_pop_o);
  c_mem_read: cover property (pready_o && mem_rd);
  c_cursor_pixel: cover property (adv && q.s5_incur);
  c_colour_write: cover property (clut_if.we);

endmodule
`default_nettype wire

/* File: rtl/ppc_pkg.sv */
package ppc_pkg;

  // Bus window and register byte offsets
  localparam int APB_AW = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CPOS = 12'h010;
  localparam logic [11:0] OFF_CNT = 12'h014;
  localparam logic [11:0] OFF_CCOL0 = 12'h018;
  localparam logic [11:0] OFF_CCOL1 = 12'h01c;
  localparam logic [3:0] CUR_PAGE = 4'h1;
  localparam logic [1:0] CLUT_PAGE = 2'h1;
  localparam int WORD_LSB = 2;
  localparam int CUR_PLANE_BIT = 7;

  // Control word fields: colour control low byte, cursor control above
  localparam int CC_OFF_BIT = 0;
  localparam int CC_SIZE_LSB = 2;
  localparam int CC_FMT_LSB = 4;
  localparam int CU_ON_BIT = 8;
  localparam int CU_TYPE_BIT = 9;
  localparam int CU_ILACE_BIT = 12;
  localparam int CU_POL_BIT = 13;
  localparam logic [31:0] CTRL_MASK = 32'h0000_333d;
  localparam int POS_X_LSB = 16;

  // Memories
  localparam int CLUT_AW = 8;
  localparam int CLUT_DW = 24;
  localparam int CUR_AW = 5;
  localparam int CUR_DW = 32;
  localparam logic [11:0] CUR_DIM = 12'h020;

  // Colour constants
  localparam logic [7:0] ALPHA_OPAQUE = 8'hff;
  localparam logic [7:0] ALPHA_LUT = 8'h00;

  // Delayed timing vector bit positions
  localparam int TB_HS = 0;
  localparam int TB_VS = 1;
  localparam int TB_BLK = 2;
  localparam int TB_FLD = 3;
  localparam int PIPE_STAGES = 7;

  typedef enum logic [1:0] {PS_8 = 2'h0, PS_16 = 2'h1, PS_32 = 2'h2}
    ppc_psize_t;
  typedef enum logic [1:0] {FMT_565 = 2'h0, FMT_4444 = 2'h1} ppc_fmt_t;
  typedef enum logic [1:0] {BS_IDLE = 2'h0, BS_HOLD1 = 2'h1,
    BS_HOLD2 = 2'h3} ppc_bus_t;
  typedef enum logic [2:0] {AK_CTRL = 3'h0, AK_CPOS = 3'h1, AK_CNT = 3'h2,
    AK_CCOL0 = 3'h3, AK_CCOL1 = 3'h4, AK_CUR = 3'h5, AK_CLUT = 3'h6,
    AK_NONE = 3'h7} ppc_kind_t;

endpackage

/* File: rtl/ppc_ram_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ppc_ram_if #(parameter int AW = 8, parameter int DW = 24);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface
`default_nettype wire

/* File: testbench/pixel_pipeline_cursor_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module pixel_pipeline_cursor_tb_top
  import ppc_pkg::*;
;
  localparam logic [23:0] COL0 = 24'h12_3456;
  localparam logic [23:0] COL1 = 24'hab_cdef;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e, mon_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pop, pclk, hs_n, vs_n, bl_n, fld, hs_o, vs_o, bl_o, fld_o;
  logic [63:0] word, ex;
  logic [7:0] a_o, r_o, g_o, b_o;
  logic [1:0] sz, fmt, code;
  logic coff, c_on, c_type;
  int curx, pops, idx;
  int err_count = 0;
  int cmp_count = 0;

  ppc_pixel_pipeline i_ppc_pixel_pipeline (.mclk_i(mclk), .rst_n_i(rst_n),
    .ce_i(1'b1), .pixel_clock_i(pclk), .hsync_n_i(hs_n), .vsync_n_i(vs_n),
    .blank_n_i(bl_n), .field_i(fld), .pixel_word_in_i(word),
    .fifo_pop_o(pop), .alpha_o(a_o), .red_o(r_o), .green_o(g_o),
    .blue_o(b_o), .hsync_n_o(hs_o), .vsync_n_o(vs_o), .blank_n_o(bl_o),
    .field_o(fld_o), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));

  ppc_far_model i_ppc_far_model (.mclk_i(mclk), .fifo_pop_i(pop),
    .pixel_clock_o(pclk), .hsync_n_o(hs_n), .vsync_n_o(vs_n),
    .blank_n_o(bl_n), .field_o(fld), .pixel_word_o(word));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pixel i of an active line as it should leave the pipeline, with mask
  function automatic logic [63:0] exp_pix(input int i);
    logic [63:0] w;
    logic [31:0] p;
    logic [31:0] m;
    logic [15:0] hw;
    logic [7:0] bb;
    logic [7:0] kk;
    logic [1:0] sel;
    kk = 8'(i / (8 >> sz));
    w = {8'ha0 | kk, 8'hb0 | kk, 8'hc0 | kk, 8'hd0 | kk, 8'h10 | kk,
      8'h20 | kk, 8'h30 | kk, 8'h40 | kk};
    bb = w[8 * (i % 8) +: 8];
    hw = w[16 * (i % 4) +: 16];
    m = 32'hffff_ffff;
    p = w[32 * (i % 2) +: 32];
    if (sz == 2'h0)
      p = {8'h00, ~bb, bb, bb ^ 8'h5a};
    // Low bits of an expansion are left open, only the field bits count
    if (sz == 2'h1 && fmt == 2'h0)
    begin
      p = {8'hff, hw[15:11], 3'h0, hw[10:5], 2'h0, hw[4:0], 3'h0};
      m = 32'hfff8_fcf8;
    end
    if (sz == 2'h1 && fmt == 2'h1)
    begin
      p = {hw[15:12], 4'h0, hw[11:8], 4'h0, hw[7:4], 4'h0, hw[3:0], 4'h0};
      m = 32'hf0f0_f0f0;
    end
    sel = c_type ? (code[1] ? {1'b0, code[0]} : 2'h2) : code;
    if (c_on && i >= curx)
      case (sel)
        2'h0: p = {8'h00, COL0};
        2'h1: p = {8'h00, COL1};
        2'h3: p = p ^ 32'h00ff_ffff;
        default: p = p;
      endcase
    if (c_on && i >= curx && sel[1] == 1'b0)
      m = m & 32'h00ff_ffff;
    if (coff)
      p = 32'h0;
    return {m, p & m};
  endfunction

  // Sample half a dot after the output register has settled
  always @(negedge pclk)
  begin
    #25;
    if (bl_o !== 1'b1)
      idx = 0;
    else
    begin
      ex = exp_pix(idx);
      if (mon_on)
        `CHK("colour", ex[31:0], {a_o, r_o, g_o, b_o} & ex[63:32])
      idx++;
    end
  end

  always @(posedge mclk)
    if (mon_on && pop === 1'b1)
      pops++;

  task automatic mode(input string nm, input logic [1:0] s,
    input logic [1:0] f, input logic off, input logic on, input logic ty,
    input logic [1:0] cd, input int x);
    sz = s;
    fmt = f;
    coff = off;
    c_on = on;
    c_type = ty;
    code = cd;
    curx = x;
    for (int i = 0; i < 32 && on; i++)
    begin
      apb(1'b1, 12'h100 + 12'(4 * i), {32{cd[0]}});
      apb(1'b1, 12'h180 + 12'(4 * i), {32{cd[1]}});
    end
    apb(1'b1, OFF_CPOS, {4'h0, 12'(x), 16'h0});
    apb(1'b1, OFF_CTRL, 32'(ty) << CU_TYPE_BIT | 32'(on) << CU_ON_BIT |
      32'(f) << CC_FMT_LSB | 32'(s) << CC_SIZE_LSB | 32'(off));
    @(negedge vs_n);
    mon_on = 1'b1;
    pops = 0;
    @(negedge vs_n);
    mon_on = 1'b0;
    `CHK(nm, 8 << s, pops)
    $display("test %s done", nm);
  endtask

  initial
  begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mon_on = 1'b0;
    {sz, fmt, code, coff, c_on, c_type} = 9'h000;
    curx = 0;
    idx = 0;
    pops = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'hffff_ffff);
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", CTRL_MASK, q)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {e, q})
    apb(1'b1, 12'h104, 32'h5a5a_0ff0);
    apb(1'b1, 12'h1fc, 32'h0123_4567);
    apb(1'b0, 12'h104, 32'h0);
    `CHK("cur_lo", 32'h5a5a_0ff0, q)
    apb(1'b0, 12'h1fc, 32'h0);
    `CHK("cur_hi", 32'h0123_4567, q)
    for (int i = 0; i < 256; i++)
      apb(1'b1, 12'h400 + 12'(4 * i), {8'h00, ~8'(i), 8'(i), 8'(i) ^ 8'h5a});
    apb(1'b0, 12'h4dc, 32'h0);
    `CHK("table", {8'h00, 8'hc8, 8'h37, 8'h6d}, q)
    $display("test registers done");
    apb(1'b1, OFF_CCOL0, {8'h00, COL0});
    apb(1'b1, OFF_CCOL1, {8'h00, COL1});
    mode("px8", 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 0);
    mode("px16_565", 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 0);
    mode("px16_4444", 2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 0);
    mode("px32", 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 0);
    mode("colour_off", 2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 0);
    for (int c = 0; c < 8; c++)
      mode("cursor", 2'h2, 2'h0, 1'b0, 1'b1, c[2], c[1:0], 0);
    mode("cur_corner", 2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 2'h0, 15);
    mode("cur_hidden", 2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 2'h0, 16);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: testbench/ppc_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ppc_far_model (
  input wire logic mclk_i,
  input wire logic fifo_pop_i,
  output logic pixel_clock_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic blank_n_o,
  output logic field_o,
  output logic [63:0] pixel_word_o
);
  int h = 0;
  int v = 0;
  logic [7:0] k = 8'h00;

  // Edges offset 3 ns from the system clock so the two never coincide; the phase between them stays fixed
  initial
  begin
    pixel_clock_o = 1'b0;
    field_o = 1'b0;
    #3;
    forever #40 pixel_clock_o = ~pixel_clock_o;
  end

  // Small raster: 28 dots a line with 16 active, 6 lines with rows 2..5 active
  always @(posedge pixel_clock_o)
  begin
    h <= (h + 1) % 28;
    if (h == 27)
      v <= (v + 1) % 6;
    if (h == 27 && v == 5)
      field_o <= ~field_o;
  end

  assign hsync_n_o = !(h >= 20 && h < 24);
  assign vsync_n_o = (v != 0);
  assign blank_n_o = (v >= 2) && (h < 16);

  // Replays one scan line: the word index restarts during blanking
  always @(posedge mclk_i)
    if (!blank_n_o)
      k <= 8'h00;
    else if (fifo_pop_i)
      k <= k + 8'h01;

  assign pixel_word_o = {8'ha0 | k, 8'hb0 | k, 8'hc0 | k, 8'hd0 | k,
    8'h10 | k, 8'h20 | k, 8'h30 | k, 8'h40 | k};
endmodule
`default_nettype wire
